// File: core/bus_events_if.sv
// Sampled line events passed from the line sampler to the sequencer
`timescale 1ns/10ps
interface bus_events_if;
  logic scl_rise;
  logic scl_fall;
  logic sda_in;
  logic start;
  logic stop;
  logic [2:0] strap;

  modport src (output scl_rise, scl_fall, sda_in, start, stop, strap);
  modport dst (input scl_rise, scl_fall, sda_in, start, stop, strap);
endinterface

// File: core/bus_sampler.sv
// Synchronises the bus pins and straps and finds edges and conditions
`timescale 1ns/10ps
module bus_sampler (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [2:0] strap_i,
  bus_events_if.src ev
);
  logic [4:0] meta_ff;
  logic [4:0] sync_ff;
  logic scl_d_ff;
  logic sda_d_ff;
  logic scl_s;
  logic sda_s;

  // --------------------------------------------------------------
  // Two-stage synchronisers and one-cycle history
  // --------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      meta_ff <= 5'h03;
      sync_ff <= 5'h03;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end
    else
    begin
      meta_ff <= {strap_i, sda_i, scl_i};
      sync_ff <= meta_ff;
      scl_d_ff <= sync_ff[0];
      sda_d_ff <= sync_ff[1];
    end
  end

  // --------------------------------------------------------------
  // Edge and condition decode
  // --------------------------------------------------------------
  assign scl_s = sync_ff[0];
  assign sda_s = sync_ff[1];
  assign ev.scl_rise = scl_s & ~scl_d_ff;
  assign ev.scl_fall = ~scl_s & scl_d_ff;
  assign ev.sda_in = sda_s;
  assign ev.start = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign ev.stop = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
  assign ev.strap = sync_ff[4:2];
endmodule // bus_sampler

// File: core/eeprom_map.svh
// Constants for the two-wire serial memory target
`ifndef EEPROM_MAP_SVH
`define EEPROM_MAP_SVH

// Device address word layout
`define DEV_TYPE 4'hA
`define DEV_RW_BIT 0
`define DEV_PAGE_BIT 1

// Word and address widths, bits per word on the wire
`define DATA_W 8
`define ADDR_W 9
`define BIT_LAST 4'h8

// Page sizes as low address bits per variant
`define PAGE_LSB_SMALL 3
`define PAGE_LSB_LARGE 4
`define PAGE_MAX 16

// Self-timed program cycle
`define PROG_TIME_MS 5
`define CLK_PERIOD_NS 4
`define PROG_CYCLES_DEF ((`PROG_TIME_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// File: core/eeprom_pkg.sv
// Types shared by the serial memory target modules
package eeprom_pkg;

  // Protocol sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_DEV = 4'h1,
    ST_DEV_ACK = 4'h2,
    ST_WADDR = 4'h3,
    ST_WADDR_ACK = 4'h4,
    ST_WDATA = 4'h5,
    ST_WDATA_ACK = 4'h6,
    ST_RDATA = 4'h7,
    ST_RACK = 4'h8,
    ST_PROG = 4'h9
  } seq_state_e;

endpackage

// File: core/eeprom_slave.sv
// Two-wire serial memory target: protocol sequencer and program cycle
`timescale 1ns/10ps
`include "eeprom_map.svh"
module eeprom_slave #(
  parameter bit LARGE = 1'b0,
  parameter int unsigned PROG_CYCLES = `PROG_CYCLES_DEF,
  parameter int FIFO_DEPTH = `PAGE_MAX
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic strap_select_bit_hi_i,
  input wire logic strap_select_bit_mid_i,
  input wire logic strap_select_bit_lo_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic [`ADDR_W-1:0] rd_addr_o,
  input wire logic [`DATA_W-1:0] rd_data_i,
  output logic wr_valid_o,
  input wire logic wr_ready_i,
  output logic [`ADDR_W-1:0] wr_addr_o,
  output logic [`DATA_W-1:0] wr_data_o,
  output logic standby_o
);
  import eeprom_pkg::*;

  localparam int EW = `ADDR_W + `DATA_W;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  seq_state_e state_ff;
  seq_state_e nxt_state;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic [7:0] shift_ff;
  logic [7:0] nxt_shift;
  logic [`ADDR_W-1:0] addr_ff;
  logic [`ADDR_W-1:0] nxt_addr;
  logic oe_ff;
  logic nxt_oe;
  logic rw_ff;
  logic nxt_rw;
  logic page_ff;
  logic nxt_page;
  logic host_ack_ff;
  logic nxt_host_ack;
  logic wrote_ff;
  logic nxt_wrote;
  logic [31:0] timer_ff;
  logic [31:0] nxt_timer;
  logic standby_ff;
  logic wr_valid_ff;
  logic [`ADDR_W-1:0] wr_addr_ff;
  logic [`DATA_W-1:0] wr_data_ff;
  logic push;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [EW-1:0] fifo_out_data;

  bus_events_if ev ();

  // ----------------------------------------------------------------
  // Pin sampling and condition detection
  // ----------------------------------------------------------------
  bus_sampler u_sampler (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .strap_i({strap_select_bit_hi_i, strap_select_bit_mid_i,
              strap_select_bit_lo_i}),
    .ev(ev.src)
  );

  // ----------------------------------------------------------------
  // Address decode and counter arithmetic
  // ----------------------------------------------------------------
  wire byte_done = ev.scl_fall & (cnt_ff == `BIT_LAST);
  wire type_ok = shift_ff[7:4] == `DEV_TYPE;
  wire strap_small = shift_ff[3:1] == ev.strap;
  wire strap_large = shift_ff[3:2] == ev.strap[2:1];
  wire dev_match = type_ok & (LARGE ? strap_large : strap_small);
  wire [`ADDR_W-1:0] word_addr = LARGE ? {page_ff, shift_ff}
                                       : {1'b0, shift_ff};
  wire [`ADDR_W-1:0] page_inc_small =
    {addr_ff[`ADDR_W-1:3], addr_ff[2:0] + 3'h1};
  wire [`ADDR_W-1:0] page_inc_large =
    {addr_ff[`ADDR_W-1:4], addr_ff[3:0] + 4'h1};
  wire [`ADDR_W-1:0] page_inc = LARGE ? page_inc_large
                                      : page_inc_small;
  wire [`ADDR_W-1:0] rd_inc = LARGE ? addr_ff + 9'h001
                                    : {1'b0, addr_ff[7:0] + 8'h01};

  // ----------------------------------------------------------------
  // Program cycle drain of the page buffer
  // ----------------------------------------------------------------
  wire in_prog = state_ff == ST_PROG;
  wire stage_free = ~wr_valid_ff | wr_ready_i;
  wire pop = in_prog & fifo_out_valid & stage_free;
  wire timer_zero = timer_ff == 32'h0;
  wire prog_done = timer_zero & ~fifo_out_valid & ~wr_valid_ff;

  page_fifo #(
    .W(EW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .in_valid_i(push),
    .in_ready_o(fifo_in_ready),
    .in_data_i({addr_ff, shift_ff}),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(pop),
    .out_data_o(fifo_out_data)
  );

  // ----------------------------------------------------------------
  // Sequencer next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_shift = shift_ff;
    nxt_addr = addr_ff;
    nxt_oe = oe_ff;
    nxt_rw = rw_ff;
    nxt_page = page_ff;
    nxt_host_ack = host_ack_ff;
    nxt_wrote = wrote_ff;
    nxt_timer = timer_ff;
    push = 1'b0;
    if (in_prog)
    begin
      // Bus is ignored entirely, so polling gets no acknowledge
      if (!timer_zero)
        nxt_timer = timer_ff - 32'h1;
      if (prog_done)
        nxt_state = ST_IDLE;
    end
    else if (ev.start)
    begin
      nxt_state = ST_DEV;
      nxt_cnt = 4'h0;
      nxt_oe = 1'b0;
    end
    else if (ev.stop)
    begin
      nxt_oe = 1'b0;
      nxt_cnt = 4'h0;
      if (wrote_ff)
      begin
        nxt_state = ST_PROG;
        nxt_timer = PROG_CYCLES;
        nxt_wrote = 1'b0;
      end
      else
        nxt_state = ST_IDLE;
    end
    else
    begin
      unique case (state_ff)
        ST_IDLE:
        begin
          nxt_oe = 1'b0;
        end
        ST_DEV, ST_WADDR, ST_WDATA:
        begin
          if (ev.scl_rise)
          begin
            nxt_shift = {shift_ff[6:0], ev.sda_in};
            nxt_cnt = cnt_ff + 4'h1;
          end
          else if (byte_done)
          begin
            nxt_cnt = 4'h0;
            if (state_ff == ST_DEV)
            begin
              nxt_rw = shift_ff[`DEV_RW_BIT];
              nxt_page = shift_ff[`DEV_PAGE_BIT];
              nxt_oe = dev_match;
              nxt_state = dev_match ? ST_DEV_ACK : ST_IDLE;
            end
            else if (state_ff == ST_WADDR)
            begin
              nxt_addr = word_addr;
              nxt_oe = 1'b1;
              nxt_state = ST_WADDR_ACK;
            end
            else if (fifo_in_ready)
            begin
              push = 1'b1;
              nxt_wrote = 1'b1;
              nxt_addr = page_inc;
              nxt_oe = 1'b1;
              nxt_state = ST_WDATA_ACK;
            end
            else
            begin
              nxt_oe = 1'b0;
              nxt_state = ST_IDLE;
            end
          end
        end
        ST_DEV_ACK:
        begin
          if (ev.scl_fall)
          begin
            nxt_cnt = 4'h0;
            if (rw_ff)
            begin
              nxt_shift = rd_data_i;
              nxt_oe = ~rd_data_i[7];
              nxt_state = ST_RDATA;
            end
            else
            begin
              nxt_oe = 1'b0;
              nxt_state = ST_WADDR;
            end
          end
        end
        ST_WADDR_ACK, ST_WDATA_ACK:
        begin
          if (ev.scl_fall)
          begin
            nxt_oe = 1'b0;
            nxt_state = ST_WDATA;
          end
        end
        ST_RDATA:
        begin
          if (ev.scl_rise)
            nxt_cnt = cnt_ff + 4'h1;
          else if (byte_done)
          begin
            nxt_oe = 1'b0;
            nxt_addr = rd_inc;
            nxt_state = ST_RACK;
          end
          else if (ev.scl_fall)
          begin
            nxt_shift = {shift_ff[6:0], 1'b0};
            nxt_oe = ~shift_ff[6];
          end
        end
        ST_RACK:
        begin
          if (ev.scl_rise)
            nxt_host_ack = ~ev.sda_in;
          else if (ev.scl_fall)
          begin
            nxt_cnt = 4'h0;
            if (host_ack_ff)
            begin
              nxt_shift = rd_data_i;
              nxt_oe = ~rd_data_i[7];
              nxt_state = ST_RDATA;
            end
            else
              nxt_state = ST_IDLE;
          end
        end
        default:
        begin
          nxt_state = ST_IDLE;
          nxt_oe = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      oe_ff <= 1'b0;
      rw_ff <= 1'b0;
      page_ff <= 1'b0;
      host_ack_ff <= 1'b0;
      wrote_ff <= 1'b0;
      timer_ff <= 32'h0;
      standby_ff <= 1'b1;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      oe_ff <= nxt_oe;
      rw_ff <= nxt_rw;
      page_ff <= nxt_page;
      host_ack_ff <= nxt_host_ack;
      wrote_ff <= nxt_wrote;
      timer_ff <= nxt_timer;
      standby_ff <= nxt_state == ST_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Address counter, kept apart so reset leaves it at zero
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      addr_ff <= '0;
    else
      addr_ff <= nxt_addr;
  end

  // ----------------------------------------------------------------
  // Array write stage fed from the page buffer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      wr_valid_ff <= 1'b0;
      wr_addr_ff <= '0;
      wr_data_ff <= 8'h00;
    end
    else if (pop)
    begin
      wr_valid_ff <= 1'b1;
      wr_addr_ff <= fifo_out_data[EW-1:`DATA_W];
      wr_data_ff <= fifo_out_data[`DATA_W-1:0];
    end
    else if (wr_ready_i)
      wr_valid_ff <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sda_o = 1'b0;
  assign sda_oe_o = oe_ff;
  assign rd_addr_o = addr_ff;
  assign wr_valid_o = wr_valid_ff;
  assign wr_addr_o = wr_addr_ff;
  assign wr_data_o = wr_data_ff;
  assign standby_o = standby_ff;
endmodule // eeprom_slave

// File: core/page_fifo.sv
// Synchronous FIFO holding page bytes until the program cycle
`timescale 1ns/10ps
module page_fifo #(
  parameter int W = 17,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [CW-1:0] count_ff;
  wire do_push = in_valid_i & in_ready_o;
  wire do_pop = out_valid_o & out_ready_i;

  // Flags follow the occupancy count
  assign in_ready_o = count_ff != CW'(DEPTH);
  assign out_valid_o = count_ff != '0;
  assign out_data_o = mem[rd_ptr_ff];

  // Storage array
  always_ff @(posedge clk_i)
  begin
    if (do_push)
      mem[wr_ptr_ff] <= in_data_i;
  end

  // Pointers and count
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end
    else
    begin
      if (do_push)
        wr_ptr_ff <= PW'((wr_ptr_ff + 1'b1) % DEPTH);
      if (do_pop)
        rd_ptr_ff <= PW'((rd_ptr_ff + 1'b1) % DEPTH);
      count_ff <= count_ff + CW'(do_push) - CW'(do_pop);
    end
  end
endmodule // page_fifo

// File: tb/bus_ctl_model.sv
// Behavioural two-wire bus controller facing the memory target
`timescale 1ns/10ps
module bus_ctl_model (
  output logic scl_o,
  output logic sda_low_o,
  input wire logic sda_i
);
  // Bus idles released with the clock standing high
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // One bit out; the line moves only while the clock is low
  task automatic put_bit(input logic b);
    sda_low_o = ~b;
    #40 scl_o = 1'b1;
    #80 scl_o = 1'b0;
    #40;
  endtask
  // One bit in, sampled in mid clock-high
  task automatic get_bit(output logic b);
    sda_low_o = 1'b0;
    #40 scl_o = 1'b1;
    #40 b = sda_i;
    #40 scl_o = 1'b0;
    #40;
  endtask
  task automatic start_c();
    sda_low_o = 1'b0;
    #40 scl_o = 1'b1;
    #40 sda_low_o = 1'b1;
    #40 scl_o = 1'b0;
    #40;
  endtask
  task automatic stop_c();
    sda_low_o = 1'b1;
    #40 scl_o = 1'b1;
    #40 sda_low_o = 1'b0;
    #80;
  endtask
  // Word out MSB first, then the ninth clock reads the answer
  task automatic put_byte(input logic [7:0] d, output logic ack_n);
    for (int i = 7; i >= 0; i--)
      put_bit(d[i]);
    get_bit(ack_n);
  endtask
  task automatic get_byte(input logic ack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      get_bit(d[i]);
    put_bit(~ack);
  endtask
  // Frees a stuck bus, then opens a command
  task automatic recover();
    logic b;
    for (int i = 0; i < 9 && sda_i !== 1'b1; i++)
      get_bit(b);
    start_c();
  endtask
endmodule // bus_ctl_model

// File: tb/eeprom_slave_monitor.sv
// Protocol checker bound to the serial memory target
`timescale 1ns/10ps
`include "eeprom_map.svh"
module eeprom_slave_monitor #(
  parameter bit LARGE = 1'b0
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic strap_select_bit_hi_i,
  input wire logic strap_select_bit_mid_i,
  input wire logic strap_select_bit_lo_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic [`ADDR_W-1:0] rd_addr_o,
  input wire logic [`DATA_W-1:0] rd_data_i,
  input wire logic wr_valid_o,
  input wire logic wr_ready_i,
  input wire logic [`ADDR_W-1:0] wr_addr_o,
  input wire logic [`DATA_W-1:0] wr_data_o,
  input wire logic standby_o
);
  localparam int PLSB = LARGE ? `PAGE_LSB_LARGE : `PAGE_LSB_SMALL;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // ----
  // Array write handshake steps
  // ----
  sequence s_take;
    wr_valid_o && wr_ready_i;
  endsequence
  sequence s_stall;
    wr_valid_o && !wr_ready_i;
  endsequence
  // Reset leaves the bus released and the counter cleared
  a_reset_quiet: assert property (disable iff (1'b0)
    srst_i |=> standby_o && !sda_oe_o && !wr_valid_o && rd_addr_o == '0)
    else $error("State after reset is not quiet");
  a_drive_low_only: assert property (sda_o == 1'b0)
    else $error("Data line driven high");
  a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("Data drive changed with bus clock high");
  a_drive_after_fall: assert property (
    $rose(sda_oe_o) |-> !scl_i && $past(scl_i, 8))
    else $error("Data drive not launched by a clock fall");
  a_ack_holds: assert property ($rose(sda_oe_o) |-> sda_oe_o [*8])
    else $error("Data drive too short");
  a_busy_silent: assert property (
    wr_valid_o |-> !sda_oe_o && !standby_o)
    else $error("Bus answered during program cycle");
  a_stall_hold: assert property (s_stall |=> wr_valid_o &&
    $stable(wr_addr_o) && $stable(wr_data_o))
    else $error("Array write dropped while stalled");
  a_page_kept: assert property (s_take ##1 wr_valid_o |->
    (wr_addr_o >> PLSB) == ($past(wr_addr_o) >> PLSB))
    else $error("Page write left its page");
  a_standby_done: assert property ($rose(standby_o) |-> !wr_valid_o)
    else $error("Standby with write pending");
endmodule // eeprom_slave_monitor
bind eeprom_slave eeprom_slave_monitor #(.LARGE(LARGE)) u_mon (
  .clk_i, .srst_i, .scl_i, .sda_i, .strap_select_bit_hi_i,
  .strap_select_bit_mid_i, .strap_select_bit_lo_i, .sda_o, .sda_oe_o,
  .rd_addr_o, .rd_data_i, .wr_valid_o, .wr_ready_i, .wr_addr_o,
  .wr_data_o, .standby_o);

// File: tb/tb.sv
// Self-checking bench for the two-wire serial memory target
`timescale 1ns/10ps
module tb;
  localparam int PROG = 2000;
  logic clk_i;
  logic srst_i = 1'b1;
  logic [2:0] strap = 3'b101;
  logic wr_ready = 1'b0;
  logic scl, ctl_low, sda_o, sda_oe, wr_valid, standby, ack;
  logic [8:0] rd_addr, wr_addr;
  logic [7:0] rd_data, wr_data, d;
  logic [7:0] mem [512];
  // Second target, large variant, lowest strap deliberately low
  logic [2:0] strap_l = 3'b010;
  logic sda_o2, sda_oe2, wr_valid2, standby2;
  logic [8:0] rd_addr2, wr_addr2;
  logic [7:0] rd_data2, wr_data2;
  logic [7:0] mem2 [512];
  wire sda = (sda_oe ? sda_o : 1'b1) & (sda_oe2 ? sda_o2 : 1'b1) & ~ctl_low;
  int fail_count = 0;
  int checked = 0;
  // ----
  // Clock, array model and parties
  // ----
  initial
  begin
    for (int i = 0; i < 512; i++)
    begin
      mem[i] = 8'(i) ^ 8'h3C;
      mem2[i] = 8'(i) ^ 8'hC3;
    end
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  assign rd_data = mem[rd_addr];
  assign rd_data2 = mem2[rd_addr2];
  // Write port stalls every other cycle
  always @(posedge clk_i)
  begin
    wr_ready <= #1 ~wr_ready;
    if (wr_valid && wr_ready)
      mem[wr_addr] <= wr_data;
    if (wr_valid2 && wr_ready)
      mem2[wr_addr2] <= wr_data2;
  end
  bus_ctl_model ctl (.scl_o(scl), .sda_low_o(ctl_low), .sda_i(sda));
  eeprom_slave #(.PROG_CYCLES(PROG)) DUT (.clk_i, .srst_i, .scl_i(scl),
    .sda_i(sda), .strap_select_bit_hi_i(strap[2]),
    .strap_select_bit_mid_i(strap[1]), .strap_select_bit_lo_i(strap[0]),
    .sda_o, .sda_oe_o(sda_oe), .rd_addr_o(rd_addr), .rd_data_i(rd_data),
    .wr_valid_o(wr_valid), .wr_ready_i(wr_ready), .wr_addr_o(wr_addr),
    .wr_data_o(wr_data), .standby_o(standby));
  eeprom_slave #(.LARGE(1'b1), .PROG_CYCLES(PROG)) DUT2 (.clk_i, .srst_i,
    .scl_i(scl), .sda_i(sda), .strap_select_bit_hi_i(strap_l[2]),
    .strap_select_bit_mid_i(strap_l[1]),
    .strap_select_bit_lo_i(strap_l[0]), .sda_o(sda_o2),
    .sda_oe_o(sda_oe2), .rd_addr_o(rd_addr2), .rd_data_i(rd_data2),
    .wr_valid_o(wr_valid2), .wr_ready_i(wr_ready), .wr_addr_o(wr_addr2),
    .wr_data_o(wr_data2), .standby_o(standby2));
  // ----
  // Shared tasks
  // ----
  task automatic check(input string what, input logic [8:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (fail_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (standby !== 1'b1 || standby2 !== 1'b1)
    begin
      @(posedge clk_i);
      #1 n++;
      if (n > 2 * PROG)
      begin
        fail_count++;
        give_verdict();
      end
    end
  endtask
  task automatic dev_word(input logic [7:0] w, input logic nak);
    ctl.start_c();
    ctl.put_byte(w, ack);
    check("device ack", {8'h00, ack}, {8'h00, nak});
  endtask
  task automatic set_addr(input logic [7:0] a);
    dev_word(8'hAA, 1'b0);
    ctl.put_byte(a, ack);
    check("address ack", {8'h00, ack}, 9'h000);
  endtask
  task automatic read_chk(input logic more, input logic [7:0] exp);
    ctl.get_byte(more, d);
    check("read data", {1'b0, d}, {1'b0, exp});
  endtask
  // ----
  // Scenarios
  // ----
  task automatic sc_mismatch();
    logic [7:0] w [4] = '{8'hA8, 8'hAE, 8'hA2, 8'hBA};
    foreach (w[i])
    begin
      dev_word(w[i], 1'b1);
      ctl.put_byte(8'h00, ack);
      check("ignored ack", {8'h00, ack}, 9'h001);
      ctl.stop_c();
    end
  endtask
  task automatic sc_byte_write();
    longint t0;
    set_addr(8'hFF);
    ctl.put_byte(8'h5A, ack);
    check("data ack", {8'h00, ack}, 9'h000);
    ctl.stop_c();
    t0 = $time;
    dev_word(8'hAA, 1'b1);
    ctl.stop_c();
    wait_idle();
    // Stop edge lies 20 cycles before t0
    t0 = ($time - t0) / 4;
    check("cycle time", {8'h00, t0 >= PROG - 20 && t0 <= PROG + 10},
      9'h001);
    dev_word(8'hAA, 1'b0);
    ctl.stop_c();
    check("stored byte", {1'b0, mem[255]}, 9'h05A);
    check("counter", rd_addr, 9'h0F8);
  endtask
  task automatic sc_reads();
    dev_word(8'hAB, 1'b0);
    read_chk(1'b0, 8'hF8 ^ 8'h3C);
    ctl.stop_c();
    check("counter", rd_addr, 9'h0F9);
    set_addr(8'hFE);
    dev_word(8'hAB, 1'b0);
    read_chk(1'b1, 8'hFE ^ 8'h3C);
    read_chk(1'b1, 8'h5A);
    read_chk(1'b0, 8'h3C);
    ctl.stop_c();
    check("counter", rd_addr, 9'h001);
    check("standby", {8'h00, standby}, 9'h001);
  endtask
  task automatic sc_page_write();
    set_addr(8'h13);
    for (int k = 0; k < 17; k++)
    begin
      ctl.put_byte(8'h40 + 8'(k), ack);
      check("page ack", {8'h00, ack}, {8'h00, k == 16});
    end
    ctl.stop_c();
    wait_idle();
    for (int j = 0; j < 8; j++)
      check("page byte", {1'b0, mem[16 + j]},
        9'h048 + 9'((j + 5) & 7));
  endtask
  // Large variant: page bit from device word, 16-byte page wrap
  task automatic sc_large();
    dev_word(8'hA6, 1'b0);
    ctl.put_byte(8'h2E, ack);
    check("large addr ack", {8'h00, ack}, 9'h000);
    for (int k = 0; k < 3; k++)
    begin
      ctl.put_byte(8'h71 + 8'(k), ack);
      check("large ack", {8'h00, ack}, 9'h000);
    end
    ctl.stop_c();
    wait_idle();
    check("large byte", {1'b0, mem2[9'h12E]}, 9'h071);
    check("large wrap", {1'b0, mem2[9'h120]}, 9'h073);
    dev_word(8'hA6, 1'b0);
    ctl.put_byte(8'h2F, ack);
    dev_word(8'hA7, 1'b0);
    read_chk(1'b1, 8'h72);
    read_chk(1'b0, 8'h30 ^ 8'hC3);
    ctl.stop_c();
    check("large counter", rd_addr2, 9'h131);
  endtask
  // ----
  // Main sequence
  // ----
  initial
  begin
    repeat (10) @(posedge clk_i);
    #1 srst_i = 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    check("standby", {8'h00, standby}, 9'h001);
    check("counter", rd_addr, 9'h000);
    ctl.recover();
    ctl.stop_c();
    sc_mismatch();
    sc_byte_write();
    sc_reads();
    sc_page_write();
    sc_large();
    give_verdict();
  end
endmodule // tb
